/* verilog/usb_bd_pkg.sv */
/*
  Shared constants and types of the descriptor table and interrupt funnel:
  register offsets, descriptor field positions, buffering modes and the
  structs that carry the serial engine's requests and answers.
  Assumes a single clock domain and a 32-bit APB register bus.
*/
`default_nettype none
package usb_bd_pkg;

  localparam int NUM_EP = 16;
  localparam int NUM_BD = 64;
  localparam int ADDR_W = 12;
  localparam int STAT_W = 7;
  localparam int ERR_W = 8;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] OFF_CONFIG = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_STAT_FLAGS = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_STAT_EN = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_ERR_FLAGS = 12'h00c;
  localparam logic [ADDR_W-1:0] OFF_ERR_EN = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_PTR = 12'h014;
  // Descriptor n sits at byte offset 0x100 + 4n.
  localparam logic [3:0] BD_BASE_HI = 4'h1;

  // Config register fields.
  localparam int CFG_MODE_LO = 0;
  localparam int CFG_EN = 2;
  localparam int CFG_PTR_RST = 3;

  // Byte lanes of a descriptor word.
  localparam int LANE_STAT = 0;
  localparam int LANE_CNT = 1;

  // Descriptor status byte fields.
  localparam int ST_OWN = 7;
  localparam int ST_DTS = 6;
  localparam int ST_PID_LO = 2;
  localparam int ST_TOGGLE_CHECK_ENABLE = 3;
  localparam int ST_BUFFER_STALL_REQUEST = 2;
  localparam int ST_BC_HI = 1;

  // Top-level status flag positions.
  localparam int IRQ_ERR_SUM = 1;
  localparam int IRQ_TRN = 3;
  // The error summary is derived, never stored.
  localparam logic [STAT_W-1:0] STAT_STICKY = 7'h7d;

  typedef enum logic [1:0] {
    PP_NONE = 2'h0,
    PP_EP0_OUT = 2'h1,
    PP_ALL = 2'h2,
    PP_ALL_BUT_EP0 = 2'h3
  } pp_mode_t;

  typedef enum logic [1:0] {
    APB_IDLE = 2'h1,
    APB_ACCESS = 2'h2
  } apb_state_t;

  typedef struct packed {
    logic valid;
    logic [3:0] ep;
    logic dirIn;
  } lookup_req_t;

  typedef struct packed {
    logic valid;
    logic [5:0] index;
    logic engineOwns;
    logic stall;
    logic checkToggle;
    logic toggleValue;
    logic [9:0] count;
  } lookup_rsp_t;

  typedef struct packed {
    logic valid;
    logic [3:0] ep;
    logic dirIn;
    logic [3:0] pid;
    logic [9:0] count;
  } done_t;

endpackage : usb_bd_pkg
`default_nettype wire

/* verilog/bd_index_map.sv */
/*
  Maps an endpoint, a direction and an even/odd pointer to a descriptor
  index under each of the four buffering modes. Purely combinational; the
  lookup caller registers the result; the completion caller uses it directly.
*/
`timescale 1ns/1ps
`default_nettype none
module bd_index_map (
  // Selection
  input wire usb_bd_pkg::pp_mode_t mode,
  input wire logic [3:0] ep,
  input wire logic dirIn,
  input wire logic odd,
  // Result
  output logic [5:0] index
);

  logic [5:0] k2;
  logic [5:0] k4;
  logic [5:0] dir2;

  assign k2 = {1'b0, ep, 1'b0};
  assign k4 = {ep, 2'b00};
  assign dir2 = {4'h0, dirIn, 1'b0};

  always_comb begin
    unique case (mode)
      usb_bd_pkg::PP_NONE: begin
        index = k2 + {5'h00, dirIn};
      end
      usb_bd_pkg::PP_EP0_OUT: begin
        if (ep == 4'h0) begin
          index = dirIn ? 6'h02 : {5'h00, odd};
        end else begin
          index = k2 + 6'h01 + {5'h00, dirIn};
        end
      end
      usb_bd_pkg::PP_ALL: begin
        index = k4 + dir2 + {5'h00, odd};
      end
      usb_bd_pkg::PP_ALL_BUT_EP0: begin
        if (ep == 4'h0) begin
          index = {5'h00, dirIn};
        end else begin
          index = k4 - 6'h02 + dir2 + {5'h00, odd};
        end
      end
    endcase
  end

endmodule : bd_index_map
`default_nettype wire

/* verilog/usb_bd_table_irq.sv */
/*
  Descriptor table and interrupt funnel of a full-speed USB device block.
  Holds 64 four-byte descriptors reachable over APB, answers the serial
  engine's descriptor lookups, writes back completion results, tracks the
  even/odd pointers and funnels status and error flags into one request.
  Assumes the serial engine runs on the same clock and drives its event
  inputs for one cycle per event.
*/
`timescale 1ns/1ps
`default_nettype none
// Operation
// - No ping-pong: OUT 2k, IN 2k+1.
// - EP0 OUT ping-pong: 0/1, 2, then shifted.
// - All ping-pong: OUT 4k/4k+1, IN 4k+2/4k+3.
// - All but EP0: EP0 0,1; others 4k-2.
// - Sixty-four descriptors, four bytes each.
// - Descriptor storage is never reset.
// - Completion writes token PID into status 5:2.
// - Toggle value ignored unless checking enabled.
// - Flags and enables live in separate registers.
// - All sources funnel into one request line.
// - Status sources each have flag and enable.
// - Enabled error flags raise the error summary.
// - Config field selects one of four modes.
// - Per-endpoint pointer, toggles per completion.
// - Owner bit one means engine owns descriptor.
module usb_bd_table_irq #(
  parameter int ERR_W = usb_bd_pkg::ERR_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [usb_bd_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial engine side
  input wire usb_bd_pkg::lookup_req_t lookupReq,
  output usb_bd_pkg::lookup_rsp_t lookupRsp,
  input wire usb_bd_pkg::done_t doneEv,
  input wire logic [usb_bd_pkg::STAT_W-1:0] statusEvents,
  input wire logic [ERR_W-1:0] errorEvents,
  // Interrupt
  output logic combinedIrq
);

  localparam int NEP = usb_bd_pkg::NUM_EP;
  localparam int NBD = usb_bd_pkg::NUM_BD;
  localparam int SW = usb_bd_pkg::STAT_W;

  function automatic logic isBdAddr(input logic [usb_bd_pkg::ADDR_W-1:0] a);
    isBdAddr = (a[11:8] == usb_bd_pkg::BD_BASE_HI) && (a[1:0] == 2'h0);
  endfunction : isBdAddr

  // Descriptor storage, one 32-bit word per descriptor.
  logic [31:0] bdMem_q [NBD];

  usb_bd_pkg::pp_mode_t ppMode_q;
  logic enable_q;
  logic [NEP-1:0] ppOdd_q;
  logic [SW-1:0] statFlags_q;
  logic [SW-1:0] statEn_q;
  logic [ERR_W-1:0] errFlags_q;
  logic [ERR_W-1:0] errEn_q;
  usb_bd_pkg::apb_state_t apbState_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  usb_bd_pkg::lookup_rsp_t lookupRsp_q;
  logic combinedIrq_q;

  logic [5:0] lookupIdx;
  logic [5:0] doneIdx;
  logic [7:0] lookupStat;
  logic [7:0] doneStat;
  logic doneHit;
  logic xferDone;
  logic cpuWr;
  logic cfgWr;
  logic ptrClear;
  logic errSummary;
  logic [SW-1:0] statView;
  logic [SW-1:0] statSet;
  logic [SW-1:0] statClr;
  logic [ERR_W-1:0] errClr;

  bd_index_map mapLookup (
    .mode(ppMode_q),
    .ep(lookupReq.ep),
    .dirIn(lookupReq.dirIn),
    .odd(ppOdd_q[lookupReq.ep]),
    .index(lookupIdx)
  );

  bd_index_map mapDone (
    .mode(ppMode_q),
    .ep(doneEv.ep),
    .dirIn(doneEv.dirIn),
    .odd(ppOdd_q[doneEv.ep]),
    .index(doneIdx)
  );

  assign lookupStat = bdMem_q[lookupIdx][8*usb_bd_pkg::LANE_STAT +: 8];
  assign doneStat = bdMem_q[doneIdx][8*usb_bd_pkg::LANE_STAT +: 8];
  // A completion only counts on a descriptor that the engine holds.
  assign doneHit = doneEv.valid && doneStat[usb_bd_pkg::ST_OWN];
  assign xferDone = pready_q && psel && penable;
  assign cpuWr = xferDone && pwrite;
  assign cfgWr = cpuWr && (paddr == usb_bd_pkg::OFF_CONFIG) && pstrb[0];
  // Pointers return to even when the block is switched on or on request.
  assign ptrClear = cfgWr && ((pwdata[usb_bd_pkg::CFG_EN] && !enable_q) ||
                              pwdata[usb_bd_pkg::CFG_PTR_RST]);
  assign errSummary = |(errFlags_q & errEn_q);

  always_comb begin
    statView = statFlags_q;
    statView[usb_bd_pkg::IRQ_ERR_SUM] = errSummary;
    statSet = statusEvents & usb_bd_pkg::STAT_STICKY;
    statSet[usb_bd_pkg::IRQ_TRN] = statSet[usb_bd_pkg::IRQ_TRN] | doneHit;
    statClr = '0;
    errClr = '0;
    // Only bits actually returned to software are cleared, so an event
    // landing between the setup and access edges survives.
    if (xferDone && !pwrite && paddr == usb_bd_pkg::OFF_STAT_FLAGS) begin
      statClr = prdata_q[SW-1:0];
    end
    if (xferDone && !pwrite && paddr == usb_bd_pkg::OFF_ERR_FLAGS) begin
      errClr = prdata_q[ERR_W-1:0];
    end
  end

  // APB handshake: one cycle of setup, answer in the first access cycle.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      apbState_q <= usb_bd_pkg::APB_IDLE;
      pready_q <= 1'b0;
    end else begin
      unique case (apbState_q)
        usb_bd_pkg::APB_IDLE: begin
          if (psel && !penable) begin
            apbState_q <= usb_bd_pkg::APB_ACCESS;
            pready_q <= 1'b1;
          end
        end
        usb_bd_pkg::APB_ACCESS: begin
          apbState_q <= usb_bd_pkg::APB_IDLE;
          pready_q <= 1'b0;
        end
      endcase
    end
  end

  // Read data and error are prepared at the setup edge.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (apbState_q == usb_bd_pkg::APB_IDLE && psel && !penable) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
      if (isBdAddr(paddr)) begin
        prdata_q <= bdMem_q[paddr[7:2]];
      end else begin
        unique case (paddr)
          usb_bd_pkg::OFF_CONFIG: begin
            prdata_q[usb_bd_pkg::CFG_MODE_LO +: 2] <= ppMode_q;
            prdata_q[usb_bd_pkg::CFG_EN] <= enable_q;
          end
          usb_bd_pkg::OFF_STAT_FLAGS: prdata_q[SW-1:0] <= statView;
          usb_bd_pkg::OFF_STAT_EN: prdata_q[SW-1:0] <= statEn_q;
          usb_bd_pkg::OFF_ERR_FLAGS: prdata_q[ERR_W-1:0] <= errFlags_q;
          usb_bd_pkg::OFF_ERR_EN: prdata_q[ERR_W-1:0] <= errEn_q;
          usb_bd_pkg::OFF_PTR: prdata_q[NEP-1:0] <= ppOdd_q;
          default: pslverr_q <= 1'b1;
        endcase
      end
    end
  end

  // Descriptor bytes hold the last software write or engine write-back; there is no reset.
  always_ff @(posedge clk) begin
    if (cpuWr && isBdAddr(paddr)) begin
      for (int b = 0; b < 4; b++) begin
        if (pstrb[b]) begin
          bdMem_q[paddr[7:2]][8*b +: 8] <= pwdata[8*b +: 8];
        end
      end
    end
    // The engine's write-back follows and so wins a same-cycle collision.
    if (doneHit) begin
      bdMem_q[doneIdx][8*usb_bd_pkg::LANE_STAT + usb_bd_pkg::ST_OWN] <= 1'b0;
      bdMem_q[doneIdx][8*usb_bd_pkg::LANE_STAT + usb_bd_pkg::ST_PID_LO +: 4] <=
        doneEv.pid;
      bdMem_q[doneIdx][8*usb_bd_pkg::LANE_STAT +: 2] <= doneEv.count[9:8];
      bdMem_q[doneIdx][8*usb_bd_pkg::LANE_CNT +: 8] <= doneEv.count[7:0];
    end
  end

  // Configuration: buffering mode and enable.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ppMode_q <= usb_bd_pkg::PP_NONE;
      enable_q <= 1'b0;
    end else if (cfgWr) begin
      ppMode_q <= usb_bd_pkg::pp_mode_t'(pwdata[usb_bd_pkg::CFG_MODE_LO +: 2]);
      enable_q <= pwdata[usb_bd_pkg::CFG_EN];
    end
  end

  // Even/odd pointers, one per endpoint.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ppOdd_q <= '0;
    end else if (ptrClear) begin
      ppOdd_q <= '0;
    end else if (doneHit) begin
      ppOdd_q[doneEv.ep] <= !ppOdd_q[doneEv.ep];
    end
  end

  // Sticky flags: hardware set wins over the read clear.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      statFlags_q <= '0;
      errFlags_q <= '0;
    end else begin
      statFlags_q <= ((statFlags_q & ~statClr) | statSet) & usb_bd_pkg::STAT_STICKY;
      errFlags_q <= (errFlags_q & ~errClr) | errorEvents;
    end
  end

  // Enables are kept apart from the flags and only gate the error summary and the request.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      statEn_q <= '0;
      errEn_q <= '0;
    end else if (cpuWr && pstrb[0]) begin
      if (paddr == usb_bd_pkg::OFF_STAT_EN) begin
        statEn_q <= pwdata[SW-1:0];
      end
      if (paddr == usb_bd_pkg::OFF_ERR_EN) begin
        errEn_q <= pwdata[ERR_W-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      combinedIrq_q <= 1'b0;
    end else begin
      combinedIrq_q <= |(statView & statEn_q);
    end
  end

  // Lookup answer for the serial engine, one cycle after the request.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lookupRsp_q <= '0;
    end else begin
      lookupRsp_q.valid <= lookupReq.valid;
      lookupRsp_q.index <= lookupIdx;
      lookupRsp_q.engineOwns <= lookupStat[usb_bd_pkg::ST_OWN];
      lookupRsp_q.stall <= lookupStat[usb_bd_pkg::ST_BUFFER_STALL_REQUEST];
      lookupRsp_q.checkToggle <= lookupStat[usb_bd_pkg::ST_TOGGLE_CHECK_ENABLE];
      lookupRsp_q.toggleValue <= lookupStat[usb_bd_pkg::ST_TOGGLE_CHECK_ENABLE] &&
                                 lookupStat[usb_bd_pkg::ST_DTS];
      lookupRsp_q.count <= {lookupStat[usb_bd_pkg::ST_BC_HI -: 2],
                            bdMem_q[lookupIdx][8*usb_bd_pkg::LANE_CNT +: 8]};
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign lookupRsp = lookupRsp_q;
  assign combinedIrq = combinedIrq_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  AST_MAP_NONE: assert property (
    lookupReq.valid && ppMode_q == usb_bd_pkg::PP_NONE |=>
      lookupRsp.index == {1'b0, $past(lookupReq.ep), $past(lookupReq.dirIn)})
    else $error("No ping-pong lookup index wrong.");

  AST_MAP_EP0OUT: assert property (
    lookupReq.valid && ppMode_q == usb_bd_pkg::PP_EP0_OUT && lookupReq.ep != 4'h0 |=>
      lookupRsp.index == {1'b0, $past(lookupReq.ep), 1'b1} + {5'h00, $past(lookupReq.dirIn)})
    else $error("Endpoint zero OUT mode index wrong.");

  AST_MAP_ALL: assert property (
    lookupReq.valid && ppMode_q == usb_bd_pkg::PP_ALL |=>
      lookupRsp.index[5:1] == {$past(lookupReq.ep), $past(lookupReq.dirIn)})
    else $error("All ping-pong index wrong.");

  AST_MAP_BUT0: assert property (
    lookupReq.valid && ppMode_q == usb_bd_pkg::PP_ALL_BUT_EP0 && lookupReq.ep == 4'h0 |=>
      lookupRsp.index == {5'h00, $past(lookupReq.dirIn)})
    else $error("Endpoint zero index wrong in mode three.");

  AST_PID_WRITE: assert property (
    doneHit |=> bdMem_q[$past(doneIdx)][5:2] == $past(doneEv.pid) &&
                !bdMem_q[$past(doneIdx)][usb_bd_pkg::ST_OWN])
    else $error("Completion write-back missing.");

  AST_TOGGLE_GATED: assert property (
    lookupRsp.toggleValue |-> lookupRsp.checkToggle)
    else $error("Toggle value passed without check enable.");

  AST_FLAG_NO_ENABLE: assert property (
    statusEvents[usb_bd_pkg::IRQ_TRN + 1] && statEn_q == '0 |=>
      statFlags_q[usb_bd_pkg::IRQ_TRN + 1] ##1 !combinedIrq)
    else $error("Flag not captured apart from its enable.");

  AST_ERR_FUNNEL: assert property (
    errorEvents != '0 && (errorEvents & errEn_q) != '0 &&
      statEn_q[usb_bd_pkg::IRQ_ERR_SUM] && $stable(errEn_q) |=> ##1 combinedIrq)
    else $error("Enabled error did not reach the request.");

  AST_IRQ_SOURCE: assert property (
    $rose(combinedIrq) |-> $past(|(statView & statEn_q)))
    else $error("Request rose without an enabled flag.");

  AST_PTR_TOGGLE: assert property (
    doneHit && !ptrClear |=> ppOdd_q[$past(doneEv.ep)] != $past(ppOdd_q[doneEv.ep]))
    else $error("Pointer did not toggle on completion.");

  AST_PTR_CLEAR: assert property (
    ptrClear |=> ppOdd_q == '0)
    else $error("Pointers not reset to even.");

  COV_PP_ALL_ODD: cover property (
    lookupReq.valid && ppMode_q == usb_bd_pkg::PP_ALL && ppOdd_q[lookupReq.ep]);
  COV_DONE: cover property (doneHit ##[1:20] combinedIrq);
  COV_READ_CLEAR: cover property (statClr != '0 ##1 statFlags_q == '0);
  COV_SET_CLEAR_CLASH: cover property ((statSet & statClr) != '0);

endmodule : usb_bd_table_irq
`default_nettype wire

/* bench/engine_model.sv */
/*
  Behavioural serial engine that stands on the far side of the block: it
  issues descriptor lookups, completions and event pulses when told to.
  Assumes the block answers a lookup exactly one cycle after taking it.
*/
`timescale 1ns/1ps
`default_nettype none
module engine_model (
  // Clock
  input wire logic clk,
  // Requests to the block
  output var usb_bd_pkg::lookup_req_t lookupReq,
  output var usb_bd_pkg::done_t doneEv,
  output var logic [usb_bd_pkg::STAT_W-1:0] statusEvents,
  output var logic [usb_bd_pkg::ERR_W-1:0] errorEvents,
  // Answers
  input wire usb_bd_pkg::lookup_rsp_t lookupRsp
);
  initial begin
    lookupReq = '0;
    doneEv = '0;
    statusEvents = '0;
    errorEvents = '0;
  end

  // Idle fields are inverted so that nothing can lean on stale values.
  task automatic lookup(input logic [3:0] ep, input logic dirIn,
                        output usb_bd_pkg::lookup_rsp_t rsp);
    @(posedge clk);
    lookupReq <= '{valid: 1'b1, ep: ep, dirIn: dirIn};
    @(posedge clk);
    lookupReq <= '{valid: 1'b0, ep: ~ep, dirIn: ~dirIn};
    @(posedge clk);
    rsp = lookupRsp;
  endtask : lookup

  task automatic complete(input logic [3:0] ep, input logic dirIn,
                          input logic [3:0] pid, input logic [9:0] cnt);
    @(posedge clk);
    doneEv <= '{valid: 1'b1, ep: ep, dirIn: dirIn, pid: pid, count: cnt};
    @(posedge clk);
    doneEv <= '{valid: 1'b0, ep: ~ep, dirIn: ~dirIn, pid: ~pid, count: ~cnt};
  endtask : complete

  task automatic pulse(input logic [usb_bd_pkg::STAT_W-1:0] s,
                       input logic [usb_bd_pkg::ERR_W-1:0] e);
    @(posedge clk);
    statusEvents <= s;
    errorEvents <= e;
    @(posedge clk);
    statusEvents <= '0;
    errorEvents <= '0;
  endtask : pulse
endmodule : engine_model
`default_nettype wire

/* bench/usb_bd_table_and_irq_funnel_tb_top.sv */
/*
  Self-checking bench of the descriptor table and interrupt funnel.
  Assumes a zero-wait APB slave and the engine model beside it.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin totalChecks++; if ((got) !== (exp)) begin nFail++; \
  $display("ERROR t=%0t got %h exp %h", $time, got, exp); end end
module usb_bd_table_and_irq_funnel_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic combinedIrq;
  usb_bd_pkg::lookup_req_t lookupReq;
  usb_bd_pkg::lookup_rsp_t lookupRsp;
  usb_bd_pkg::done_t doneEv;
  logic [usb_bd_pkg::STAT_W-1:0] statusEvents;
  logic [usb_bd_pkg::ERR_W-1:0] errorEvents;
  usb_bd_pkg::lookup_rsp_t rsp;
  logic [31:0] rdv;
  logic errv;
  logic [31:0] r;
  logic [7:0] st;
  logic [3:0] pid;
  logic [9:0] cnt;
  logic [15:0] ptrV;
  int nFail = 0;
  int totalChecks = 0;
  int cyc = 0;
  int e;
  int d;
  int n;
  int n2;

  always #4 clk = ~clk;

  usb_bd_table_irq i_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lookupReq(lookupReq), .lookupRsp(lookupRsp),
    .doneEv(doneEv), .statusEvents(statusEvents), .errorEvents(errorEvents),
    .combinedIrq(combinedIrq));

  engine_model i_eng (.clk(clk), .lookupReq(lookupReq), .doneEv(doneEv),
    .statusEvents(statusEvents), .errorEvents(errorEvents), .lookupRsp(lookupRsp));

  function automatic int bdIdx(int m, int ep, int di, int o);
    case (m)
      0: return 2 * ep + di;
      1: return (ep == 0) ? (di ? 2 : o) : 2 * ep + 1 + di;
      2: return 4 * ep + 2 * di + o;
      default: return (ep == 0) ? di : 4 * ep - 2 + 2 * di + o;
    endcase
  endfunction : bdIdx

  function automatic logic [11:0] bdA(int i);
    return {usb_bd_pkg::BD_BASE_HI, i[5:0], 2'b00};
  endfunction : bdA

  task automatic complete_run();
    $display("checks %0d mismatches %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  // The request is held until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // Only the cycle ceiling below ends a wait that never sees pready.
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    `CHK(rdv, exp)
    `CHK(errv, 1'b0)
  endtask : rdchk

  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      nFail++;
      complete_run();
    end
  end

  initial begin
    void'($urandom(32'h40662c97));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 24; a += 4) rdchk(a[11:0], 32'h0);
    apb(1'b0, 12'h018, 32'h0);
    `CHK({errv, rdv}, 33'h100000000)
    i_eng.pulse(7'h10, 8'h00);
    repeat (2) @(posedge clk);
    `CHK(combinedIrq, 1'b0)
    rdchk(usb_bd_pkg::OFF_STAT_FLAGS, 32'h10);
    pstrb <= 4'he;
    apb(1'b1, usb_bd_pkg::OFF_STAT_EN, 32'h7f);
    pstrb <= 4'hf;
    rdchk(usb_bd_pkg::OFF_STAT_EN, 32'h0);
    $display("test reset done");
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, usb_bd_pkg::OFF_CONFIG, m | 32'hc);
      for (e = 0; e < 16; e++) for (d = 0; d < 2; d++) begin
        i_eng.lookup(e[3:0], d[0], rsp);
        `CHK({rsp.valid, rsp.index}, {1'b1, 6'(bdIdx(m, e, d, 0))})
      end
    end
    $display("test mapping done");
    apb(1'b1, usb_bd_pkg::OFF_STAT_EN, 32'h8);
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, usb_bd_pkg::OFF_CONFIG, m | 32'hc);
      ptrV = '0;
      e = $urandom % 16;
      d = $urandom % 2;
      n = bdIdx(m, e, d, 0);
      r = $urandom;
      st = 8'h80 | (r[7:0] & 8'h4f);
      apb(1'b1, bdA(n), {r[31:8], st & 8'h7f});
      apb(1'b1, bdA(n), {r[31:8], st});
      i_eng.lookup(e[3:0], d[0], rsp);
      `CHK(rsp.index, 6'(n))
      `CHK({rsp.engineOwns, rsp.stall, rsp.checkToggle}, {1'b1, st[2], st[3]})
      `CHK(rsp.toggleValue, st[6] & st[3])
      `CHK(rsp.count, {st[1:0], r[15:8]})
      pid = 4'($urandom);
      cnt = 10'($urandom);
      i_eng.complete(e[3:0], d[0], pid, cnt);
      ptrV[e] = ~ptrV[e];
      repeat (2) @(posedge clk);
      `CHK(combinedIrq, 1'b1)
      rdchk(usb_bd_pkg::OFF_STAT_FLAGS, 32'h8);
      rdchk(bdA(n), {r[31:16], cnt[7:0], 1'b0, st[6], pid, cnt[9:8]});
      rdchk(usb_bd_pkg::OFF_PTR, {16'h0, ptrV});
      repeat (2) @(posedge clk);
      `CHK(combinedIrq, 1'b0)
      n2 = bdIdx(m, e, d, 1);
      i_eng.lookup(e[3:0], d[0], rsp);
      `CHK(rsp.index, 6'(n2))
      apb(1'b1, bdA(n2), 32'h0);
      i_eng.complete(e[3:0], d[0], pid, cnt);
      rdchk(bdA(n2), 32'h0);
      pstrb <= 4'h4;
      apb(1'b1, bdA(n2), r);
      pstrb <= 4'hf;
      rdchk(bdA(n2), {8'h00, r[23:16], 16'h0000});
      rdchk(usb_bd_pkg::OFF_PTR, {16'h0, ptrV});
      rdchk(usb_bd_pkg::OFF_STAT_FLAGS, 32'h0);
      apb(1'b1, usb_bd_pkg::OFF_CONFIG, m);
      apb(1'b1, usb_bd_pkg::OFF_CONFIG, m | 32'h4);
      rdchk(usb_bd_pkg::OFF_CONFIG, m | 32'h4);
      rdchk(usb_bd_pkg::OFF_PTR, 32'h0);
    end
    $display("test completion done");
    apb(1'b1, usb_bd_pkg::OFF_STAT_EN, 32'h2);
    repeat (6) begin
      r = $urandom;
      apb(1'b1, usb_bd_pkg::OFF_ERR_EN, {24'h0, r[7:0]});
      i_eng.pulse(r[14:8], r[23:16]);
      repeat (2) @(posedge clk);
      `CHK(combinedIrq, |(r[7:0] & r[23:16]))
      rdchk(usb_bd_pkg::OFF_STAT_FLAGS, {25'h0, (r[14:8] & usb_bd_pkg::STAT_STICKY)
        | {5'h0, |(r[7:0] & r[23:16]), 1'b0}});
      rdchk(usb_bd_pkg::OFF_ERR_FLAGS, {24'h0, r[23:16]});
      rdchk(usb_bd_pkg::OFF_STAT_FLAGS, 32'h0);
    end
    $display("test events done");
    complete_run();
  end
endmodule : usb_bd_table_and_irq_funnel_tb_top
`default_nettype wire
